// ===== logic/dov_pkg.sv
`default_nettype none
package dov_pkg;
   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int unsigned CLK_MHZ = 100;
   localparam int unsigned EXEC_NS = 1000;
   localparam int unsigned EXEC_CYCLES = EXEC_NS * CLK_MHZ / 1000;
   localparam int unsigned TICK_W = 7;
   // ****************************************************************
   // Bus
   // ****************************************************************
   localparam int unsigned DATA_W = 32;
   localparam int unsigned OFS_W = 8;
   localparam logic [1:0] HTRANS_IDLE = 2'h0;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic HRESP_OKAY = 1'h0;
   localparam logic [OFS_W-1:0] CTRL_OFS = 8'h00;
   localparam logic [OFS_W-1:0] CFG_OFS = 8'h04;
   localparam logic [OFS_W-1:0] OUT_ADDR_OFS = 8'h08;
   localparam logic [OFS_W-1:0] FB_ADDR_OFS = 8'h0c;
   localparam logic [OFS_W-1:0] STAT_OFS = 8'h10;
   // ****************************************************************
   // Register fields
   // ****************************************************************
   localparam int unsigned CTRL_W = 5;
   localparam int unsigned CTRL_CMD = 0;
   localparam int unsigned CTRL_RESTART = 1;
   localparam int unsigned CTRL_INHIBIT = 2;
   localparam int unsigned CTRL_RESTART_USED = 3;
   localparam int unsigned CTRL_INHIBIT_USED = 4;
   localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
   localparam int unsigned CFG_W = 7;
   localparam int unsigned CFG_OUT_INV = 0;
   localparam int unsigned CFG_FB_INV = 1;
   localparam int unsigned CFG_FS_LO = 2;
   localparam int unsigned CFG_SAFETY = 4;
   localparam int unsigned CFG_TYPE_LO = 5;
   localparam logic [CFG_W-1:0] CFG_RST = 7'h00;
   localparam int unsigned ADDR_W = 14;
   localparam int unsigned RACK_LO = 0;
   localparam int unsigned MOD_LO = 4;
   localparam int unsigned CHAN_LO = 8;
   localparam logic [ADDR_W-1:0] ADDR_RST = 14'h0111;
   localparam logic [2:0] RACK_MIN = 3'h1;
   localparam logic [2:0] RACK_MAX = 3'h5;
   localparam logic [3:0] MOD_MIN = 4'h1;
   localparam logic [3:0] MOD_MAX = 4'hc;
   localparam logic [5:0] CHAN_MIN = 6'h01;
   localparam logic [5:0] CHAN_MAX = 6'h20;
   localparam int unsigned ST_W = 5;
   localparam int unsigned ST_OUT = 0;
   localparam int unsigned ST_OUT_FAULT = 1;
   localparam int unsigned ST_FB_FAULT = 2;
   localparam int unsigned ST_MISMATCH = 3;
   localparam int unsigned ST_FB_VAL = 4;
   localparam logic [1:0] FS_CODE_OFF = 2'h0;
   localparam logic [1:0] FS_CODE_ON = 2'h1;
   localparam logic [1:0] FS_CODE_HOLD = 2'h2;
   localparam logic [1:0] TYPE_DC32 = 2'h0;
   localparam logic [1:0] TYPE_DC16 = 2'h1;
   localparam logic [1:0] TYPE_AC = 2'h2;
   localparam logic [1:0] TYPE_RELAY = 2'h3;

   typedef enum logic [1:0] {FS_OFF, FS_ON, FS_HOLD} failsafe_e;

   function automatic failsafe_e fs_decode(input logic [1:0] raw);
      unique case (raw)
         FS_CODE_OFF: fs_decode = FS_OFF;
         FS_CODE_ON: fs_decode = FS_ON;
         FS_CODE_HOLD: fs_decode = FS_HOLD;
         default: fs_decode = FS_OFF;
      endcase
   endfunction : fs_decode

   function automatic logic [5:0] chan_limit(input logic [1:0] kind);
      unique case (kind)
         TYPE_DC32: chan_limit = 6'h20;
         TYPE_DC16: chan_limit = 6'h10;
         TYPE_AC: chan_limit = 6'h08;
         TYPE_RELAY: chan_limit = 6'h04;
      endcase
   endfunction : chan_limit

   function automatic logic addr_ok(input logic [ADDR_W-1:0] a,
                                    input logic [5:0] lim);
      logic [2:0] rack;
      logic [3:0] mdl;
      logic [5:0] chan;
      rack = a[RACK_LO +: 3];
      mdl = a[MOD_LO +: 4];
      chan = a[CHAN_LO +: 6];
      addr_ok = (rack >= RACK_MIN) && (rack <= RACK_MAX) &&
                (mdl >= MOD_MIN) && (mdl <= MOD_MAX) &&
                (chan >= CHAN_MIN) && (chan <= lim);
   endfunction : addr_ok
endpackage : dov_pkg
`default_nettype wire

// ===== logic/pin_sampler.sv
`timescale 1ns/1ns
`default_nettype none
module pin_sampler (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic output_module_error,
   input wire logic feedback_module_error,
   input wire logic feedback_pin,
   sample_if.producer smp
);
   import dov_pkg::*;

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   logic [2:0] sync_a;
   logic [2:0] sync_b;
   logic [TICK_W-1:0] cnt;
   logic tick;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync_a <= 3'h0;
         sync_b <= 3'h0;
      end else begin
         sync_a <= {feedback_pin, feedback_module_error,
                    output_module_error};
         sync_b <= sync_a;
      end
   end

   // ****************************************************************
   // Execution cycle divider
   // ****************************************************************
   // One tick per controller cycle; all channel state moves on it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt <= '0;
         tick <= 1'b0;
      end else if (cnt == TICK_W'(EXEC_CYCLES - 1)) begin
         cnt <= '0;
         tick <= 1'b1;
      end else begin
         cnt <= cnt + 1'b1;
         tick <= 1'b0;
      end
   end

   assign smp.tick = tick;
   assign smp.do_error = sync_b[0];
   assign smp.di_error = sync_b[1];
   assign smp.feedback_level = sync_b[2];
endmodule : pin_sampler
`default_nettype wire

// ===== logic/sample_if.sv
`timescale 1ns/1ns
`default_nettype none
interface sample_if;
   logic tick;
   logic feedback_level;
   logic do_error;
   logic di_error;
   modport producer (output tick, output feedback_level,
                     output do_error, output di_error);
   modport consumer (input tick, input feedback_level,
                     input do_error, input di_error);
endinterface : sample_if
`default_nettype wire

// ===== logic/validated_digital_output.sv
// Decided for this implementation: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module validated_digital_output (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [dov_pkg::DATA_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [dov_pkg::DATA_W-1:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [dov_pkg::DATA_W-1:0] hrdata,
   input wire logic output_module_error,
   input wire logic feedback_module_error,
   input wire logic feedback_pin,
   output logic output_pin,
   output logic output_module_fault,
   output logic feedback_module_fault,
   output logic readback_mismatch
);
   import dov_pkg::*;

   // ****************************************************************
   // Declarations
   // ****************************************************************
   sample_if smp ();

   logic wr_pending;
   logic [OFS_W-1:0] wr_ofs;
   logic addr_phase;
   logic wr_now;
   logic [CTRL_W-1:0] ctrl;
   logic [CFG_W-1:0] cfg;
   logic [ADDR_W-1:0] out_addr;
   logic [ADDR_W-1:0] fb_addr;
   logic [CTRL_W-1:0] next_ctrl;
   logic [CFG_W-1:0] next_cfg;
   logic [ADDR_W-1:0] next_out_addr;
   logic [ADDR_W-1:0] next_fb_addr;
   logic [DATA_W-1:0] rd_word;
   logic [ST_W-1:0] status;
   logic restart_prev;
   logic inhibit_on;
   logic restart_used;
   logic restart_rise;
   logic commanded;
   logic fb_value;
   logic fb_val;
   logic next_fault;
   logic next_out;
   logic next_mismatch;
   failsafe_e fs_mode;

   default clocking @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   pin_sampler u_sampler (
      .hclk(hclk),
      .hresetn(hresetn),
      .output_module_error(output_module_error),
      .feedback_module_error(feedback_module_error),
      .feedback_pin(feedback_pin),
      .smp(smp.producer)
   );

   // ****************************************************************
   // Bus slave
   // ****************************************************************
   assign addr_phase = hsel && hready && (htrans[1] != HTRANS_IDLE[1]);
   assign wr_now = wr_pending && hready;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pending <= 1'b0;
         wr_ofs <= '0;
      end else if (hready) begin
         wr_pending <= addr_phase && hwrite && (hsize == HSIZE_WORD);
         wr_ofs <= haddr[OFS_W-1:0];
      end
   end

   // Stalls only from reset until the first clock after it, never errors
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b0;
         hresp <= HRESP_OKAY;
      end else begin
         hreadyout <= 1'b1;
         hresp <= HRESP_OKAY;
      end
   end

   // Out-of-range addresses are refused whole, so stored ones stay legal
   always_comb begin
      next_ctrl = ctrl;
      next_cfg = cfg;
      next_out_addr = out_addr;
      next_fb_addr = fb_addr;
      if (wr_now) begin
         unique case (wr_ofs)
            CTRL_OFS: next_ctrl = hwdata[CTRL_W-1:0];
            CFG_OFS: next_cfg = hwdata[CFG_W-1:0];
            OUT_ADDR_OFS: begin
               if (addr_ok(hwdata[ADDR_W-1:0],
                           chan_limit(cfg[CFG_TYPE_LO +: 2]))) begin
                  next_out_addr = hwdata[ADDR_W-1:0];
               end
            end
            FB_ADDR_OFS: begin
               if (addr_ok(hwdata[ADDR_W-1:0], CHAN_MAX)) begin
                  next_fb_addr = hwdata[ADDR_W-1:0];
               end
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl <= CTRL_RST;
         cfg <= CFG_RST;
         out_addr <= ADDR_RST;
         fb_addr <= ADDR_RST;
      end else begin
         ctrl <= next_ctrl;
         cfg <= next_cfg;
         out_addr <= next_out_addr;
         fb_addr <= next_fb_addr;
      end
   end

   // Reads see a write still in its data phase
   assign status = {fb_val, readback_mismatch, feedback_module_fault,
                    output_module_fault, output_pin};

   always_comb begin
      rd_word = '0;
      unique case (haddr[OFS_W-1:0])
         CTRL_OFS: rd_word[CTRL_W-1:0] = next_ctrl;
         CFG_OFS: rd_word[CFG_W-1:0] = next_cfg;
         OUT_ADDR_OFS: rd_word[ADDR_W-1:0] = next_out_addr;
         FB_ADDR_OFS: rd_word[ADDR_W-1:0] = next_fb_addr;
         STAT_OFS: rd_word[ST_W-1:0] = status;
         default: rd_word = '0;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= '0;
      end else if (addr_phase && !hwrite) begin
         hrdata <= rd_word;
      end
   end

   // ****************************************************************
   // Channel control
   // ****************************************************************
   assign inhibit_on = ctrl[CTRL_INHIBIT_USED] && ctrl[CTRL_INHIBIT];
   assign restart_used = ctrl[CTRL_RESTART_USED];
   assign restart_rise = restart_used && !inhibit_on &&
                         ctrl[CTRL_RESTART] && !restart_prev;
   assign commanded = ctrl[CTRL_CMD] ^ cfg[CFG_OUT_INV];
   assign fb_value = smp.feedback_level ^ cfg[CFG_FB_INV];
   assign fs_mode = cfg[CFG_SAFETY] ? FS_OFF
                                    : fs_decode(cfg[CFG_FS_LO +: 2]);

   // Restart level sampled once per execution cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         restart_prev <= 1'b0;
      end else if (smp.tick) begin
         restart_prev <= ctrl[CTRL_RESTART];
      end
   end

   // Error wins over a release arriving in the same cycle
   always_comb begin
      if (smp.do_error) begin
         next_fault = 1'b1;
      end else if (restart_used) begin
         next_fault = output_module_fault && !restart_rise;
      end else begin
         next_fault = 1'b0;
      end
   end

   always_comb begin
      if (inhibit_on) begin
         next_out = 1'b0;
      end else if (next_fault) begin
         unique case (fs_mode)
            FS_OFF: next_out = 1'b0;
            FS_ON: next_out = 1'b1;
            FS_HOLD: next_out = output_pin;
         endcase
      end else begin
         next_out = commanded;
      end
   end

   // Feedback error hides mismatch; inhibit freezes it
   always_comb begin
      if (smp.di_error) begin
         next_mismatch = 1'b0;
      end else if (inhibit_on) begin
         next_mismatch = readback_mismatch;
      end else begin
         next_mismatch = fb_value != output_pin;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         output_module_fault <= 1'b0;
         output_pin <= 1'b0;
      end else if (smp.tick) begin
         output_module_fault <= next_fault;
         output_pin <= next_out;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         feedback_module_fault <= 1'b0;
         readback_mismatch <= 1'b0;
         fb_val <= 1'b0;
      end else if (smp.tick) begin
         feedback_module_fault <= smp.di_error;
         readback_mismatch <= next_mismatch;
         fb_val <= fb_value;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   chk_out_invert: assert property (
      smp.tick && !inhibit_on && !next_fault |=>
      output_pin == $past(ctrl[CTRL_CMD] ^ cfg[CFG_OUT_INV]))
      else $error("output not command xor invert");

   chk_fb_polarity: assert property (
      smp.tick && cfg[CFG_FB_INV] |=> fb_val != $past(smp.feedback_level))
      else $error("feedback not inverted");

   chk_restart_release: assert property (
      smp.tick && restart_rise && !smp.do_error && output_module_fault
      |=> (!output_module_fault) [*3])
      else $error("restart edge did not release fault");

   chk_unlatched_follow: assert property (
      smp.tick && !restart_used |=>
      output_module_fault == $past(smp.do_error))
      else $error("unlatched fault not following error");

   chk_inhibit_off: assert property (
      smp.tick && inhibit_on |=> !output_pin)
      else $error("inhibited output driven");

   chk_inhibit_restart: assert property (
      smp.tick && inhibit_on && output_module_fault && restart_used
      |=> output_module_fault)
      else $error("restart acted while inhibited");

   chk_fault_set: assert property (
      smp.tick && smp.do_error |=> output_module_fault)
      else $error("module error did not set fault");

   chk_safety_off: assert property (
      smp.tick && smp.do_error && cfg[CFG_SAFETY] |=> !output_pin)
      else $error("safety instance not failing off");

   chk_fs_on: assert property (
      smp.tick && smp.do_error && !inhibit_on && !cfg[CFG_SAFETY] &&
      fs_decode(cfg[CFG_FS_LO +: 2]) == FS_ON |=> output_pin)
      else $error("failsafe on not driving on");

   chk_fs_hold: assert property (
      smp.tick && smp.do_error && !inhibit_on && fs_mode == FS_HOLD
      |=> $stable(output_pin))
      else $error("failsafe hold changed output");

   chk_fb_fault: assert property (
      $rose(smp.di_error) |-> ##[1:120] feedback_module_fault)
      else $error("feedback fault not raised");

   chk_mismatch_calc: assert property (
      smp.tick && !smp.di_error && !inhibit_on |=>
      readback_mismatch == ($past(fb_value) != $past(output_pin)))
      else $error("mismatch flag wrong");

   chk_mismatch_quiet: assert property (
      feedback_module_fault |-> !readback_mismatch)
      else $error("mismatch set during feedback fault");

   chk_out_addr_range: assert property (
      addr_ok(out_addr, CHAN_MAX))
      else $error("output address out of range");

   chk_fb_addr_range: assert property (
      addr_ok(fb_addr, CHAN_MAX))
      else $error("feedback address out of range");

   chk_level_no_release: assert property (
      smp.tick && restart_used && restart_prev && output_module_fault
      |=> output_module_fault)
      else $error("held restart level released fault");

   chk_mismatch_frozen: assert property (
      smp.tick && inhibit_on && !smp.di_error |=>
      $stable(readback_mismatch))
      else $error("mismatch changed while inhibited");
endmodule : validated_digital_output
`default_nettype wire

// ===== verif/io_module_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// Physical output module and its feedback input module
// ****************************************************************
module io_module_model (
   input wire logic hclk,
   input wire logic output_pin,
   input wire logic do_broken,
   input wire logic di_broken,
   input wire logic wire_cut,
   output logic output_module_error,
   output logic feedback_module_error,
   output logic feedback_pin
);
   logic field_level;
   initial field_level = 1'b0;
   initial feedback_pin = 1'b0;
   assign output_module_error = do_broken;
   assign feedback_module_error = di_broken;
   // Contact lags the driven point; a cut wire reads as open
   always @(posedge hclk) begin
      field_level <= wire_cut ? 1'b0 : output_pin;
   end
   // Failed input module gives no usable level, so toggle each cycle
   always @(posedge hclk) begin
      if (di_broken) begin
         feedback_pin <= ~feedback_pin;
      end else begin
         feedback_pin <= field_level;
      end
   end
endmodule : io_module_model
`default_nettype wire

// ===== verif/validated_digital_output_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module validated_digital_output_tb_top;
   import dov_pkg::*;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize, wr_size;
   logic out_pin, ofault, fbfault, mism, o_err, f_err, fb_pin;
   logic do_broken, di_broken, wire_cut;
   int num_errors, check_count, cycles;
   logic [31:0] rd;

   validated_digital_output validated_digital_output_i (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .output_module_error(o_err),
      .feedback_module_error(f_err), .feedback_pin(fb_pin),
      .output_pin(out_pin), .output_module_fault(ofault),
      .feedback_module_fault(fbfault), .readback_mismatch(mism));

   io_module_model io_module_model_i (
      .hclk(hclk), .output_pin(out_pin), .do_broken(do_broken),
      .di_broken(di_broken), .wire_cut(wire_cut),
      .output_module_error(o_err), .feedback_module_error(f_err),
      .feedback_pin(fb_pin));

   // ****************************************************************
   // Clock and run limit
   // ****************************************************************
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   // About 26 channel steps of 300 cycles plus bus traffic
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         end_of_test();
      end
   end

   // ****************************************************************
   // Bus and compare tasks
   // ****************************************************************
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   // Ready is taken at the rising edge, before that edge's updates land
   task automatic wait_ready();
      do begin
         @(posedge hclk);
      end while (hreadyout !== 1'b1);
   endtask : wait_ready

   task automatic bus_write(input logic [7:0] ofs, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      haddr <= {24'h000000, ofs};
      hwrite <= 1'b1;
      hsize <= wr_size;
      wait_ready();
      hsel <= 1'b0;
      htrans <= HTRANS_IDLE;
      hwdata <= d;
      wait_ready();
   endtask : bus_write

   task automatic bus_read(input logic [7:0] ofs, output logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      haddr <= {24'h000000, ofs};
      hwrite <= 1'b0;
      hsize <= HSIZE_WORD;
      wait_ready();
      hsel <= 1'b0;
      htrans <= HTRANS_IDLE;
      wait_ready();
      d = hrdata;
      check({31'h0, hresp}, {31'h0, HRESP_OKAY});
   endtask : bus_read

   task automatic reg_chk(input logic [7:0] ofs, input logic [31:0] exp);
      logic [31:0] d;
      bus_read(ofs, d);
      check(d, exp);
   endtask : reg_chk

   // Expected nibble is {mismatch, feedback fault, output fault, pin}
   task automatic step(input logic [4:0] ctrl, input logic [6:0] cfg,
                       input logic [2:0] faults, input logic [3:0] exp);
      logic [31:0] st;
      bus_write(CTRL_OFS, {27'h0, ctrl});
      bus_write(CFG_OFS, {25'h0, cfg});
      {do_broken, di_broken, wire_cut} <= faults;
      // Three tick periods: sync, one tick to act, one to compare
      repeat (300) @(posedge hclk);
      @(negedge hclk);
      check({28'h0, mism, fbfault, ofault, out_pin}, {28'h0, exp});
      bus_read(STAT_OFS, st);
      check(st & 32'h0000000f, {28'h0, exp});
   endtask : step

   task automatic end_of_test();
      $display("checks=%0d errors=%0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_of_test

   // ****************************************************************
   // Sequence
   // ****************************************************************
   initial begin
      {hresetn, hsel, hwrite, do_broken, di_broken, wire_cut} = 6'h00;
      {haddr, hwdata} = 64'h0;
      htrans = HTRANS_IDLE;
      hsize = HSIZE_WORD;
      wr_size = HSIZE_WORD;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      reg_chk(CTRL_OFS, 32'h00000000);
      reg_chk(CFG_OFS, 32'h00000000);
      reg_chk(OUT_ADDR_OFS, 32'h00000111);
      reg_chk(FB_ADDR_OFS, 32'h00000111);
      reg_chk(8'h14, 32'h00000000);
      bus_write(STAT_OFS, 32'h0000001f);
      reg_chk(STAT_OFS, 32'h00000000);
      bus_write(CFG_OFS, 32'h0000007f);
      reg_chk(CFG_OFS, 32'h0000007f);
      wr_size <= 3'h0;
      bus_write(CFG_OFS, 32'h00000060);
      wr_size <= HSIZE_WORD;
      reg_chk(CFG_OFS, 32'h0000007f);
      // Relay module type limits the output channel to four
      bus_write(CFG_OFS, 32'h00000060);
      bus_write(OUT_ADDR_OFS, 32'h000004c5);
      reg_chk(OUT_ADDR_OFS, 32'h000004c5);
      bus_write(OUT_ADDR_OFS, 32'h000005c5);
      reg_chk(OUT_ADDR_OFS, 32'h000004c5);
      bus_write(OUT_ADDR_OFS, 32'h000004c6);
      reg_chk(OUT_ADDR_OFS, 32'h000004c5);
      bus_write(OUT_ADDR_OFS, 32'h000004d5);
      reg_chk(OUT_ADDR_OFS, 32'h000004c5);
      bus_write(FB_ADDR_OFS, 32'h000020c5);
      reg_chk(FB_ADDR_OFS, 32'h000020c5);
      bus_write(FB_ADDR_OFS, 32'h000021c5);
      reg_chk(FB_ADDR_OFS, 32'h000020c5);
      // Sixteen-channel, then eight-channel module type
      bus_write(CFG_OFS, 32'h00000020);
      bus_write(OUT_ADDR_OFS, 32'h00001011);
      reg_chk(OUT_ADDR_OFS, 32'h00001011);
      bus_write(OUT_ADDR_OFS, 32'h00001111);
      reg_chk(OUT_ADDR_OFS, 32'h00001011);
      bus_write(CFG_OFS, 32'h00000040);
      bus_write(OUT_ADDR_OFS, 32'h00000911);
      reg_chk(OUT_ADDR_OFS, 32'h00001011);
      bus_write(OUT_ADDR_OFS, 32'h00000811);
      reg_chk(OUT_ADDR_OFS, 32'h00000811);
      bus_write(OUT_ADDR_OFS, 32'h00000810);
      reg_chk(OUT_ADDR_OFS, 32'h00000811);
      bus_write(CFG_OFS, 32'h00000000);
      bus_write(OUT_ADDR_OFS, 32'h00002011);
      reg_chk(OUT_ADDR_OFS, 32'h00002011);
      step(5'h01, 7'h00, 3'h0, 4'h1);
      step(5'h11, 7'h00, 3'h0, 4'h1);
      step(5'h01, 7'h01, 3'h0, 4'h0);
      step(5'h01, 7'h00, 3'h4, 4'h2);
      step(5'h01, 7'h00, 3'h0, 4'h1);
      step(5'h00, 7'h04, 3'h4, 4'h3);
      step(5'h00, 7'h14, 3'h4, 4'h2);
      step(5'h00, 7'h0c, 3'h4, 4'h2);
      step(5'h01, 7'h08, 3'h0, 4'h1);
      step(5'h01, 7'h08, 3'h4, 4'h3);
      step(5'h00, 7'h08, 3'h4, 4'h3);
      step(5'h09, 7'h00, 3'h4, 4'h2);
      step(5'h09, 7'h00, 3'h0, 4'h2);
      step(5'h0b, 7'h00, 3'h0, 4'h1);
      step(5'h09, 7'h00, 3'h0, 4'h1);
      step(5'h1d, 7'h00, 3'h4, 4'h2);
      step(5'h1d, 7'h00, 3'h0, 4'h2);
      step(5'h1f, 7'h00, 3'h0, 4'h2);
      step(5'h0b, 7'h00, 3'h0, 4'h2);
      step(5'h09, 7'h00, 3'h0, 4'h2);
      step(5'h0b, 7'h00, 3'h0, 4'h1);
      step(5'h01, 7'h00, 3'h1, 4'h9);
      step(5'h15, 7'h00, 3'h1, 4'h8);
      step(5'h01, 7'h00, 3'h0, 4'h1);
      reg_chk(STAT_OFS, 32'h00000011);
      step(5'h01, 7'h02, 3'h0, 4'h9);
      reg_chk(STAT_OFS, 32'h00000009);
      step(5'h01, 7'h02, 3'h2, 4'h5);
      // Mid-run reset must clear every flag set above
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(negedge hclk);
      check({28'h0, mism, fbfault, ofault, out_pin}, 32'h0);
      reg_chk(STAT_OFS, 32'h00000000);
      reg_chk(CTRL_OFS, 32'h00000000);
      end_of_test();
   end
endmodule : validated_digital_output_tb_top
`default_nettype wire
